/* File: rtl/fps_map.svh */
// fps_map.svh: opcodes, register addresses, field positions and reset values
// assumes inclusion by the protection package and the protection-state block
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH

// command opcodes
`define FPS_OP_PROT_READ 8'hA7
`define FPS_OP_PROT_LOCK 8'hA6
`define FPS_OP_READ_ANY 8'h65
`define FPS_OP_WRITE_ANY 8'h71
`define FPS_OP_LOCK_READ 8'h3D
`define FPS_OP_LOCK_READ_4B 8'hE0
`define FPS_OP_LOCK 8'h36
`define FPS_OP_LOCK_4B 8'hE1
`define FPS_OP_UNLOCK 8'h39
`define FPS_OP_UNLOCK_4B 8'hE2
`define FPS_OP_GLOBAL_LOCK 8'h7E
`define FPS_OP_GLOBAL_UNLOCK 8'h98
`define FPS_OP_SET_PTR 8'hFB
`define FPS_OP_SET_PTR_4B 8'hE3

// register addresses seen by read-any / write-any
`define FPS_RA_PROT_STATUS 32'h0000_0041
`define FPS_RA_PTR_REGION 32'h0000_0042

// protection status fields
`define FPS_PS_LOCK_BIT 0
`define FPS_PS_RDPW_BIT 6

// otp configuration fields
`define FPS_OTP_PERM_BIT 0
`define FPS_OTP_PWD_BIT 2
`define FPS_OTP_BOOT_BIT 4
`define FPS_OTP_RDPW_BIT 6

// pointer region fields
`define FPS_PTR_ADDR_HI 24
`define FPS_PTR_ADDR_LO 12
`define FPS_PTR_ALL_BIT 11
`define FPS_PTR_EN_BIT 10
`define FPS_PTR_TB_BIT 9
`define FPS_PTR_RSVD_MASK 32'hFE00_01FF
`define FPS_PTR_A24_MASK 32'h0100_0000
`define FPS_PTR_FACTORY 32'hFFFF_FFFF

// lock byte values and block granularity
`define FPS_LOCK_PROT 8'h00
`define FPS_LOCK_OPEN 8'hFF
`define FPS_BLK_SHIFT 16

`endif

/* File: rtl/fps_pkg.sv */
// fps_pkg: carrier types for the flash protection-state block
// assumes fps_map.svh is on the include path
package fps_pkg;
`include "fps_map.svh"

    typedef struct packed {
        logic valid;
        logic [7:0] op;
        logic [31:0] addr;
        logic [31:0] wdata;
    } fps_cmd_t;

    typedef struct packed {
        logic valid;
        logic refused;
        logic [31:0] data;
    } fps_rsp_t;

endpackage : fps_pkg

/* File: rtl/fps_region_check.sv */
// fps_region_check: combinational protection verdict for one flash address
// assumes a settled pointer region word and the block's lock bit alongside
`timescale 1ns/1ps
`include "fps_map.svh"
module fps_region_check #(
    parameter int ADDR_W = 25
) (
    input wire logic [31:0] ptr_region, // pointer region word
    input wire logic [ADDR_W-1:0] addr, // flash byte address
    input wire logic lock_open, // lock bit of the addressed block
    output logic prot // program and erase refused
);
    import fps_pkg::*;

    logic [ADDR_W-1:12] ptr_page;
    logic [ADDR_W-1:12] addr_page;
    logic in_region;

    always_comb begin
        ptr_page = ptr_region[ADDR_W-1:`FPS_PTR_ADDR_LO];
        addr_page = addr[ADDR_W-1:12];
        if (ptr_region[`FPS_PTR_TB_BIT]) begin
            in_region = addr_page <= ptr_page;
        end else begin
            in_region = addr_page >= ptr_page;
        end
        if (ptr_region[`FPS_PTR_ALL_BIT]) begin
            in_region = 1'b1;
        end
        // enable gates region; lock bit blocks
        prot = (~ptr_region[`FPS_PTR_EN_BIT] & in_region) | ~lock_open;
    end

endmodule : fps_region_check

/* File: rtl/fps_protect.sv */
// fps_protect: protection status, block lock array and pointer region state
// assumes decoded single-cycle commands and an outside store holding the
// non-volatile pointer region and otp configuration words
`timescale 1ns/1ps
`include "fps_map.svh"
module fps_protect #(
    parameter int ADDR_W = 25
) (
    input wire logic clk, // 125 MHz clock
    input wire logic rst_b, // asynchronous reset, active low
    input wire fps_pkg::fps_cmd_t cmd, // decoded command, one cycle
    input wire logic [15:0] otp_cfg, // otp protection configuration
    input wire logic [31:0] nv_ptr_init, // stored pointer region word
    input wire logic [ADDR_W-1:0] q_addr, // address to check
    output fps_pkg::fps_rsp_t rsp, // answer one cycle after cmd
    output logic [7:0] prot_status, // protection status byte
    output logic [31:0] ptr_region, // pointer region word
    output logic ptr_store, // pulse: persist ptr_region
    output logic q_prot, // q_addr protected, one cycle late
    output logic sec_region_wr_ok, // regions 2 and 3 writable
    output logic sec3_read_pw // region 3 reads need password
);
    import fps_pkg::*;

    localparam int NBLK = 1 << (ADDR_W - `FPS_BLK_SHIFT);
    localparam int BW = ADDR_W - `FPS_BLK_SHIFT;

    if (ADDR_W != 24 && ADDR_W != 25) begin : g_bad_width
        $error("fps_protect: ADDR_W must be 24 or 25");
    end

    typedef struct packed {
        logic load_pend;
        logic nonvolatile_lock_flag;
        logic rdpw_sel;
        logic perm;
        logic [NBLK-1:0] lock_open;
        logic [31:0] ptr;
        logic ptr_store;
        fps_rsp_t rsp;
        logic q_prot;
        logic wr_ok;
        logic rd_pw;
    } fps_state_t;

    fps_state_t st_q;
    fps_state_t st_d;
    logic check_prot;
    logic [BW-1:0] q_blk;

    function automatic logic [BW-1:0] blk_index(input logic [31:0] a, input logic four_b);
        logic [31:0] eff;
        eff = four_b ? a : {8'h00, a[23:0]};
        return eff[ADDR_W-1:`FPS_BLK_SHIFT];
    endfunction : blk_index

    function automatic logic [31:0] ptr_clean(input logic [31:0] w);
        logic [31:0] m;
        m = `FPS_PTR_RSVD_MASK;
        // A24 reserved on the smaller density
        if (ADDR_W == 24) begin
            m = m | `FPS_PTR_A24_MASK;
        end
        return w | m;
    endfunction : ptr_clean

    function automatic logic [7:0] status_byte(input logic lk, input logic rp);
        logic [7:0] s;
        s = 8'h00;
        s[`FPS_PS_LOCK_BIT] = lk;
        s[`FPS_PS_RDPW_BIT] = rp;
        return s;
    endfunction : status_byte

    assign q_blk = q_addr[ADDR_W-1:`FPS_BLK_SHIFT];

    fps_region_check #(
        .ADDR_W(ADDR_W)
    ) u_check (
        .ptr_region(st_q.ptr),
        .addr(q_addr),
        .lock_open(st_q.lock_open[q_blk]),
        .prot(check_prot)
    );

    always_comb begin
        logic ptr_wr_ok;
        logic four_b;
        logic [BW-1:0] idx;
        st_d = st_q;
        ptr_wr_ok = 1'b0;
        four_b = 1'b0;
        idx = '0;
        st_d.ptr_store = 1'b0;
        st_d.rsp = '0;
        st_d.q_prot = check_prot;
        if (st_q.load_pend) begin
            st_d.load_pend = 1'b0;
            // lock flag from password and permanent bits
            st_d.nonvolatile_lock_flag = otp_cfg[`FPS_OTP_PWD_BIT] & otp_cfg[`FPS_OTP_PERM_BIT];
            st_d.perm = otp_cfg[`FPS_OTP_PERM_BIT];
            st_d.rdpw_sel = otp_cfg[`FPS_OTP_RDPW_BIT];
            st_d.lock_open = {NBLK{~otp_cfg[`FPS_OTP_BOOT_BIT]}};
            st_d.ptr = ptr_clean(nv_ptr_init);
            if (cmd.valid) begin
                st_d.rsp.valid = 1'b1;
                st_d.rsp.refused = 1'b1;
            end
        end else if (cmd.valid) begin
            // lock flag gate; permanent bit gate
            ptr_wr_ok = st_q.nonvolatile_lock_flag & st_q.perm;
            four_b = (cmd.op == `FPS_OP_LOCK_READ_4B) || (cmd.op == `FPS_OP_LOCK_4B)
                || (cmd.op == `FPS_OP_UNLOCK_4B) || (cmd.op == `FPS_OP_SET_PTR_4B);
            idx = blk_index(cmd.addr, four_b);
            st_d.rsp.valid = 1'b1;
            case (cmd.op)
                `FPS_OP_PROT_READ: begin
                    st_d.rsp.data = {24'h00_0000, status_byte(st_q.nonvolatile_lock_flag, st_q.rdpw_sel)};
                end
                `FPS_OP_PROT_LOCK: begin
                    st_d.nonvolatile_lock_flag = 1'b1;
                end
                `FPS_OP_READ_ANY: begin
                    if (cmd.addr == `FPS_RA_PROT_STATUS) begin
                        st_d.rsp.data = {24'h00_0000, status_byte(st_q.nonvolatile_lock_flag, st_q.rdpw_sel)};
                    end else if (cmd.addr == `FPS_RA_PTR_REGION) begin
                        st_d.rsp.data = st_q.ptr;
                    end else begin
                        st_d.rsp.refused = 1'b1;
                    end
                end
                `FPS_OP_WRITE_ANY: begin
                    if (cmd.addr == `FPS_RA_PTR_REGION && ptr_wr_ok) begin
                        st_d.ptr = ptr_clean(cmd.wdata);
                        st_d.ptr_store = 1'b1;
                    end else begin
                        st_d.rsp.refused = 1'b1;
                    end
                end
                `FPS_OP_LOCK_READ, `FPS_OP_LOCK_READ_4B: begin
                    st_d.rsp.data = {24'h00_0000,
                        st_q.lock_open[idx] ? `FPS_LOCK_OPEN : `FPS_LOCK_PROT};
                end
                `FPS_OP_LOCK, `FPS_OP_LOCK_4B: begin
                    st_d.lock_open[idx] = 1'b0;
                end
                `FPS_OP_UNLOCK, `FPS_OP_UNLOCK_4B: begin
                    st_d.lock_open[idx] = 1'b1;
                end
                `FPS_OP_GLOBAL_LOCK: begin
                    st_d.lock_open = '0;
                end
                `FPS_OP_GLOBAL_UNLOCK: begin
                    st_d.lock_open = '1;
                end
                `FPS_OP_SET_PTR, `FPS_OP_SET_PTR_4B: begin
                    if (ptr_wr_ok) begin
                        st_d.ptr = ptr_clean(four_b ? cmd.addr
                            : {st_q.ptr[31:24], cmd.addr[23:0]});
                        st_d.ptr_store = 1'b1;
                    end else begin
                        st_d.rsp.refused = 1'b1;
                    end
                end
                default: begin
                    st_d.rsp.refused = 1'b1;
                end
            endcase
        end
        // regions 2 and 3 follow the same gate
        st_d.wr_ok = st_d.nonvolatile_lock_flag & st_d.perm & ~st_d.load_pend;
        // read password active only with select and lock flag low
        st_d.rd_pw = ~st_d.rdpw_sel & ~st_d.nonvolatile_lock_flag & ~st_d.load_pend;
    end

    // lock bits live only in these volatile flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q.load_pend <= 1'b1;
            st_q.nonvolatile_lock_flag <= 1'b0;
            st_q.rdpw_sel <= 1'b1;
            st_q.perm <= 1'b0;
            st_q.lock_open <= '0;
            // factory word until the stored one loads
            st_q.ptr <= `FPS_PTR_FACTORY;
            st_q.ptr_store <= 1'b0;
            st_q.rsp <= '0;
            st_q.q_prot <= 1'b1;
            st_q.wr_ok <= 1'b0;
            st_q.rd_pw <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rsp = st_q.rsp;
    assign prot_status = status_byte(st_q.nonvolatile_lock_flag, st_q.rdpw_sel);
    assign ptr_region = st_q.ptr;
    assign ptr_store = st_q.ptr_store;
    assign q_prot = st_q.q_prot;
    assign sec_region_wr_ok = st_q.wr_ok;
    assign sec3_read_pw = st_q.rd_pw;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic ready;
    assign ready = !st_q.load_pend;

    sequence set_ptr_cmd;
        ready && cmd.valid && (cmd.op == `FPS_OP_SET_PTR || cmd.op == `FPS_OP_SET_PTR_4B);
    endsequence

    sequence lock_cmd;
        ready && cmd.valid && cmd.op == `FPS_OP_PROT_LOCK;
    endsequence

    sequence lock_read_cmd;
        ready && cmd.valid
            && (cmd.op == `FPS_OP_LOCK_READ || cmd.op == `FPS_OP_LOCK_READ_4B);
    endsequence

    sequence global_lock_cmd;
        ready && cmd.valid && cmd.op == `FPS_OP_GLOBAL_LOCK;
    endsequence

    sequence global_unlock_cmd;
        ready && cmd.valid && cmd.op == `FPS_OP_GLOBAL_UNLOCK;
    endsequence

    status_readonly_a: assert property (
        ready && cmd.valid && cmd.op == `FPS_OP_WRITE_ANY && cmd.addr == `FPS_RA_PROT_STATUS
        |=> rsp.refused && $stable(prot_status))
        else $error("status register changed by write-any");

    locked_ptr_hold_a: assert property (
        set_ptr_cmd and (!prot_status[0]) |=> rsp.refused && !ptr_store && $stable(ptr_region))
        else $error("pointer region changed while locked");

    lock_load_a: assert property (
        st_q.load_pend |=> prot_status[0] == $past(otp_cfg[2] & otp_cfg[0]))
        else $error("lock flag not loaded from otp");

    lock_set_a: assert property (
        lock_cmd |=> prot_status[0] ##1 prot_status[0])
        else $error("lock command did not set flag");

    rdpw_mirror_a: assert property (
        ready |-> prot_status[6] == otp_cfg[`FPS_OTP_RDPW_BIT] && prot_status[7] == 1'b0)
        else $error("read password mirror wrong");

    status_read_a: assert property (
        ready && cmd.valid && cmd.op == `FPS_OP_PROT_READ
        |=> rsp.valid && rsp.data == {24'h00_0000, prot_status})
        else $error("status read returned wrong value");

    reserved_zero_a: assert property (
        prot_status[5:1] == 5'b0_0000)
        else $error("reserved status bits not zero");

    boot_lock_a: assert property (
        st_q.load_pend |=> st_q.lock_open == {NBLK{~$past(otp_cfg[4])}})
        else $error("lock array not loaded from boot bit");

    global_lock_a: assert property (
        ready && cmd.valid && cmd.op == `FPS_OP_GLOBAL_LOCK |=> st_q.lock_open == '0 ##1 q_prot)
        else $error("global lock not applied");

    global_unlock_a: assert property (
        ready && cmd.valid && cmd.op == `FPS_OP_GLOBAL_UNLOCK |=> st_q.lock_open == '1)
        else $error("global unlock not applied");

    ptr_write_a: assert property (
        set_ptr_cmd and (st_q.nonvolatile_lock_flag && st_q.perm)
        |=> ptr_store && !rsp.refused ##1 (!ptr_store || $past(cmd.valid)))
        else $error("pointer write not stored");

    ptr_rsvd_a: assert property (
        (ptr_region & `FPS_PTR_RSVD_MASK) == `FPS_PTR_RSVD_MASK)
        else $error("reserved pointer bits not ones");

    perm_protect_a: assert property (
        ready && !st_q.perm |-> !sec_region_wr_ok ##1 !sec_region_wr_ok)
        else $error("permanent protection not held");

    load_refuse_a: assert property (
        st_q.load_pend && cmd.valid |=> rsp.valid && rsp.refused)
        else $error("command in load cycle not refused");

    rdpw_active_a: assert property (
        ready |-> sec3_read_pw == (!prot_status[6] && !prot_status[0]))
        else $error("read password state wrong");

    answer_each_a: assert property (
        cmd.valid |=> rsp.valid)
        else $error("command not answered");

    lock_one_a: assert property (
        ready && cmd.valid && cmd.op == `FPS_OP_LOCK_4B
        |=> !st_q.lock_open[$past(cmd.addr[ADDR_W-1:`FPS_BLK_SHIFT])])
        else $error("block lock not applied");

    unlock_one_a: assert property (
        ready && cmd.valid && cmd.op == `FPS_OP_UNLOCK && cmd.addr[31:24] == 8'h00
        |=> st_q.lock_open[$past(cmd.addr[ADDR_W-1:`FPS_BLK_SHIFT])])
        else $error("block unlock not applied");

    read_open_a: assert property (
        global_unlock_cmd ##1 !cmd.valid ##1 lock_read_cmd |=> rsp.data == 32'h0000_00FF)
        else $error("lock read after global unlock wrong");

    read_locked_a: assert property (
        global_lock_cmd ##1 !cmd.valid ##1 lock_read_cmd |=> rsp.data == 32'h0000_0000)
        else $error("lock read after global lock wrong");

    perm_refuse_a: assert property (
        ready && cmd.valid && !st_q.perm && (cmd.op == `FPS_OP_SET_PTR
        || cmd.op == `FPS_OP_SET_PTR_4B || cmd.op == `FPS_OP_WRITE_ANY)
        |=> rsp.refused && !ptr_store)
        else $error("pointer write taken under permanent protection");

endmodule : fps_protect

/* File: verification/fps_host_model.sv */
// fps_host_model: command issuer standing in for the spi host controller
// assumes a device answering each command exactly one cycle after taking it
`timescale 1ns/1ps
module fps_host_model (
    input wire logic clk, // device clock
    output fps_pkg::fps_cmd_t cmd, // decoded command to device
    input wire fps_pkg::fps_rsp_t rsp, // device answer
    input wire logic ptr_store // persist pulse from device
);
    import fps_pkg::*;

    initial cmd = '0;

    // drive on falling edge, hold through the taking edge, release,
    // then let one idle edge pass so back-to-back calls never collide
    task automatic send(input logic [7:0] op, input logic [31:0] addr,
            input logic [31:0] wdata, output fps_rsp_t r, output logic st);
        cmd <= '{valid: 1'b1, op: op, addr: addr, wdata: wdata};
        @(negedge clk);
        r = rsp;
        st = ptr_store;
        // released fields show inverted values, never the last ones
        cmd <= '{valid: 1'b0, op: ~op, addr: ~addr, wdata: ~wdata};
        @(negedge clk);
    endtask : send
endmodule : fps_host_model

/* File: verification/test_flash_protection_status_regs.sv */
// test_flash_protection_status_regs: self-checking bench for fps_protect
// assumes the host model and the design package are compiled first
`timescale 1ns/1ps
module test_flash_protection_status_regs;
    import fps_pkg::*;

    typedef struct packed {
        logic [7:0] op;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic refused;
        logic [31:0] data;
        logic chk;
    } fps_row_t;

    localparam fps_row_t ROWS[20] = '{
        '{8'hA7, 32'h0, 32'h0, 1'b0, 32'h41, 1'b1},
        '{8'h65, 32'h41, 32'h0, 1'b0, 32'h41, 1'b1},
        '{8'h65, 32'h42, 32'h0, 1'b0, 32'hFFFFFFFF, 1'b1},
        '{8'h3D, 32'h10000, 32'h0, 1'b0, 32'h0, 1'b1},
        '{8'h39, 32'h10000, 32'h0, 1'b0, 32'h0, 1'b0},
        '{8'hE0, 32'h10000, 32'h0, 1'b0, 32'hFF, 1'b1},
        '{8'hE1, 32'h10000, 32'h0, 1'b0, 32'h0, 1'b0},
        '{8'h3D, 32'h10000, 32'h0, 1'b0, 32'h0, 1'b1},
        '{8'h98, 32'h0, 32'h0, 1'b0, 32'h0, 1'b0},
        '{8'hE0, 32'h1FF0000, 32'h0, 1'b0, 32'hFF, 1'b1},
        '{8'h7E, 32'h0, 32'h0, 1'b0, 32'h0, 1'b0},
        '{8'h3D, 32'h0, 32'h0, 1'b0, 32'h0, 1'b1},
        '{8'h71, 32'h41, 32'h0, 1'b1, 32'h0, 1'b0},
        '{8'hA7, 32'h0, 32'h0, 1'b0, 32'h41, 1'b1},
        '{8'h71, 32'h42, 32'h8000, 1'b0, 32'h0, 1'b0},
        '{8'h65, 32'h42, 32'h0, 1'b0, 32'hFE0081FF, 1'b1},
        '{8'hFB, 32'hFFF000, 32'h0, 1'b0, 32'h0, 1'b0},
        '{8'h65, 32'h42, 32'h0, 1'b0, 32'hFEFFF1FF, 1'b1},
        '{8'h65, 32'h99, 32'h0, 1'b1, 32'h0, 1'b1},
        '{8'h00, 32'h0, 32'h0, 1'b1, 32'h0, 1'b0}
    };

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] otp_cfg = 16'h0055;
    logic [31:0] nv_ptr_init = 32'hFFFFFFFF;
    logic [24:0] q_addr = 25'h0;
    fps_cmd_t cmd;
    fps_rsp_t rsp;
    fps_rsp_t r;
    logic st;
    logic [7:0] prot_status;
    logic [31:0] ptr_region;
    logic ptr_store;
    logic q_prot;
    logic sec_region_wr_ok;
    logic sec3_read_pw;
    int errors = 0;
    int check_count = 0;

    always #4 clk = ~clk;

    fps_protect #(.ADDR_W(25)) u_dut (.clk(clk), .rst_b(rst_b), .cmd(cmd),
        .otp_cfg(otp_cfg), .nv_ptr_init(nv_ptr_init), .q_addr(q_addr), .rsp(rsp),
        .prot_status(prot_status), .ptr_region(ptr_region), .ptr_store(ptr_store),
        .q_prot(q_prot), .sec_region_wr_ok(sec_region_wr_ok),
        .sec3_read_pw(sec3_read_pw));

    fps_host_model u_host (.clk(clk), .cmd(cmd), .rsp(rsp), .ptr_store(ptr_store));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic do_reset(input logic [15:0] otp);
        otp_cfg = otp;
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        chk(ptr_region, 32'hFFFFFFFF);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
    endtask : do_reset

    task automatic qchk(input logic [24:0] a, input logic e);
        q_addr = a;
        repeat (2) @(negedge clk);
        chk({31'h0, q_prot}, {31'h0, e});
    endtask : qchk

    task automatic wr_ptr(input logic [31:0] w);
        u_host.send(8'h71, 32'h42, w, r, st);
    endtask : wr_ptr

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        do_reset(16'h0055);
        chk({31'h0, sec3_read_pw}, 32'h0);
        chk({31'h0, sec_region_wr_ok}, 32'h1);
        for (int i = 0; i < 20; i++) begin
            u_host.send(ROWS[i].op, ROWS[i].addr, ROWS[i].wdata, r, st);
            chk({31'h0, r.valid}, 32'h1);
            chk({31'h0, r.refused}, {31'h0, ROWS[i].refused});
            chk({31'h0, st}, {31'h0, !ROWS[i].refused && ROWS[i].op inside {8'h71, 8'hFB}});
            if (ROWS[i].chk) begin
                chk(r.data, ROWS[i].data);
            end
        end
        u_host.send(8'h98, 32'h0, 32'h0, r, st);
        qchk(25'h0000000, 1'b0);
        qchk(25'h0FFF000, 1'b1);
        qchk(25'h0FFE000, 1'b0);
        qchk(25'h1000000, 1'b1);
        wr_ptr(32'h00FFF200);
        qchk(25'h0000000, 1'b1);
        qchk(25'h1000000, 1'b0);
        wr_ptr(32'h00FFF800);
        qchk(25'h0000000, 1'b1);
        wr_ptr(32'h00FFF400);
        qchk(25'h0FFF000, 1'b0);
        u_host.send(8'hE1, 32'h0, 32'h0, r, st);
        qchk(25'h0000000, 1'b1);
        do_reset(16'h0051);
        chk({24'h0, prot_status}, 32'h40);
        chk({31'h0, sec_region_wr_ok}, 32'h0);
        wr_ptr(32'h0);
        chk({31'h0, r.refused}, 32'h1);
        u_host.send(8'hFB, 32'h0, 32'h0, r, st);
        chk({31'h0, r.refused}, 32'h1);
        u_host.send(8'hA6, 32'h0, 32'h0, r, st);
        chk({24'h0, prot_status}, 32'h41);
        chk({31'h0, sec_region_wr_ok}, 32'h1);
        wr_ptr(32'h0);
        chk({31'h0, r.refused}, 32'h0);
        do_reset(16'h0044);
        chk({24'h0, prot_status}, 32'h40);
        u_host.send(8'h3D, 32'h0, 32'h0, r, st);
        chk(r.data, 32'hFF);
        u_host.send(8'hA6, 32'h0, 32'h0, r, st);
        chk({24'h0, prot_status}, 32'h41);
        wr_ptr(32'h0);
        chk({31'h0, r.refused}, 32'h1);
        chk({31'h0, sec_region_wr_ok}, 32'h0);
        // stored pointer word changes; reload seen after reset
        nv_ptr_init = 32'h0000_0400;
        // host selects region 3 read password with permanent and boot bits set, password bit clear
        do_reset(16'h0011);
        chk(ptr_region, 32'hFE0005FF);
        chk({24'h0, prot_status}, 32'h0);
        chk({31'h0, sec3_read_pw}, 32'h1);
        report_and_stop();
    end
endmodule : test_flash_protection_status_regs
